// ==== common/l2_cache_defines.vh ====
// Purpose: constants of the cacheability and coherence controller
// Assumes: byte addresses on a 32-bit register port
// Notes: reset values, offsets and field positions
// Behaviour
// - one copy-permit bit per range attribute
// - copy-permit bits except attribute zero reset to zero
// - attribute zero read-only, reads one
// - attributes one to fifteen read-only zero
// - double miss with permit zero goes long-distance
// - long read stalls cpu, dirty lru victim written on data reads only
// - permit zero keeps no l2 or data cache copy outside l2 ram
// - program cache ignores attributes
// - l2 ram coherent with data cache only
// - dma read of dirty line issues snoop-read
// - dma write to present line issues snoop-write
// - l2 evictions write dirty victims, no invalidate
// - data victims never allocate l2 lines
// - victim hit updates dirty, not lru
// - dma writes never invalidate program cache
// - shadow data tags consulted on dma access
// - snoop-read keeps line valid, no writeback
// - non-cacheable write hitting l2 handled
// - control registers at documented addresses
// - config reports core count and identifier
// - config bits nine and eight flush l1 caches
// - reserved config bits read zero
// - config bit three freezes l2 allocation
// - config bits two to zero select size
// - base first, count of 1 to ffe0 starts block op
// - global bit clears when operation completes
`ifndef L2_CACHE_DEFINES_VH
`define L2_CACHE_DEFINES_VH
`define ADDR_L2_CONFIG        32'h01840000
`define ADDR_WB_BASE          32'h01844000
`define ADDR_WB_COUNT         32'h01844004
`define ADDR_WBINV_BASE       32'h01844010
`define ADDR_WBINV_COUNT      32'h01844014
`define ADDR_INV_BASE         32'h01844018
`define ADDR_INV_COUNT        32'h0184401c
`define ADDR_GLOBAL_WB        32'h01845000
`define ADDR_GLOBAL_WBINV     32'h01845004
`define ADDR_GLOBAL_INV       32'h01845008
`define ADDR_ATTR_BASE        32'h01848000
`define ADDR_ATTR_MASK        32'hfffffc00
`define CFG_CORE_COUNT_LSB    24
`define CFG_CORE_ID_LSB       16
`define CFG_PROG_FLUSH_BIT    9
`define CFG_DATA_FLUSH_BIT    8
`define CFG_FREEZE_BIT        3
`define CFG_SIZE_MSB          2
`define CFG_RESET             4'h0
`define COUNT_MAX             16'hffe0
`define FIXED_ATTR_LAST       8'h0f
`define OP_TICKS              8'h10
`endif

// ==== logic/shadow_tag_mem.v ====
// Purpose: shadow copy of data cache tags, valid and dirty
// Assumes: one write port, one registered read port
// Notes: read data appear one cycle after the read address
`timescale 1ns/1ns
`default_nettype none
module shadow_tag_mem #(
  parameter IDX_W = 6,
  parameter TAG_W = 20
) (
  input  wire             mclk_i,
  input  wire             rst_n_i,
  input  wire             ce_i,
  input  wire             we_i,
  input  wire [IDX_W-1:0] widx_i,
  input  wire [TAG_W+1:0] wdata_i,
  input  wire [IDX_W-1:0] ridx_i,
  output reg  [TAG_W+1:0] rdata_o
);
  reg [TAG_W+1:0] mem_r [0:(1<<IDX_W)-1];
  always @(posedge mclk_i) begin
    if (ce_i && we_i) begin
      mem_r[widx_i] <= wdata_i;
    end
  end
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= {(TAG_W+2){1'b0}};
    end else if (ce_i) begin
      rdata_o <= mem_r[ridx_i];
    end
  end
endmodule
`default_nettype wire

// ==== logic/coherence_op_seq.v ====
// Purpose: one program-initiated coherence operation sequencer
// Assumes: remaining count drops by OP_TICKS per busy cycle
// Notes: count reads non-zero while running
`timescale 1ns/1ns
`default_nettype none
`include "l2_cache_defines.vh"
module coherence_op_seq (
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  input  wire        start_i,
  input  wire [15:0] count_i,
  output reg  [15:0] remain_o,
  output wire        busy_o
);
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain_o <= 16'h0000;
    end else if (ce_i) begin
      if (start_i) begin
        remain_o <= (count_i > `COUNT_MAX) ? 16'h0000 : count_i;
      end else if (remain_o != 16'h0000) begin
        remain_o <= (remain_o > {8'h00, `OP_TICKS}) ?
                    remain_o - {8'h00, `OP_TICKS} : 16'h0000;
      end
    end
  end
  assign busy_o = (remain_o != 16'h0000);
endmodule
`default_nettype wire

// ==== logic/l2_cacheability_and_l1_coherence.v ====
// Purpose: cacheability attributes, l1 coherence and l2 control registers
// Assumes: single clock, register reads return one cycle later
// Notes: l2 array and l1 caches sit outside; this block decides
`timescale 1ns/1ns
`default_nettype none
`include "l2_cache_defines.vh"
module l2_cacheability_and_l1_coherence #(
  parameter [3:0] CORE_COUNT_M1 = 4'h0,
  parameter [3:0] CORE_ID       = 4'h0,
  parameter       IDX_W         = 6,
  parameter       TAG_W         = 20
) (
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  input  wire [31:0] reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  input  wire        miss_req_i,
  input  wire        miss_prog_i,
  input  wire        miss_write_i,
  input  wire [31:0] miss_addr_i,
  input  wire        miss_l2ram_i,
  input  wire        miss_l2hit_i,
  output reg         long_access_o,
  output reg         allocate_o,
  output reg         data_l1_cache_keep_o,
  output reg         nc_write_hit_o,
  output wire        cpu_stall_o,
  output reg         lru_wb_req_o,
  input  wire        long_read_done_i,
  input  wire        victim_req_i,
  input  wire        victim_l2hit_i,
  output reg         victim_to_ext_o,
  output reg         victim_set_dirty_o,
  input  wire        l2_evict_i,
  input  wire        l2_evict_dirty_i,
  output reg         evict_wb_o,
  input  wire        shadow_we_i,
  input  wire [IDX_W-1:0] shadow_widx_i,
  input  wire [TAG_W+1:0] shadow_wdata_i,
  input  wire        dma_req_i,
  input  wire        dma_write_i,
  input  wire [31:0] dma_addr_i,
  output reg         snoop_read_cmd_o,
  output reg         snoop_write_cmd_o,
  output reg  [31:0] snoop_addr_o,
  output wire        program_cache_flush_all_o,
  output wire        data_cache_flush_all_o,
  output wire        freeze_select_o,
  output wire [2:0]  cache_size_select_o,
  output wire        coherence_busy_o
);
////////////////////////////////////////////////////////////////////////////
// register state
  reg  [3:0]  cfg_r;
  reg         pflush_r;
  reg         dflush_r;
  wire [255:0] permit;
  reg  [31:0] base_r [0:2];
  reg  [2:0]  gbl_r;
  reg  [7:0]  gcnt_r;
  reg         long_busy_r;
  wire [15:0] remain [0:2];
  wire [2:0]  blk_busy;
  wire        any_busy;
  wire        attr_hit;
  wire [7:0]  attr_idx;
  wire [7:0]  miss_idx;
  wire        miss_permit;
  assign attr_hit = ((reg_addr_i & `ADDR_ATTR_MASK) == `ADDR_ATTR_BASE);
  assign attr_idx = reg_addr_i[9:2];
  assign miss_idx = miss_addr_i[31:24];
  assign miss_permit = permit[miss_idx];
  assign any_busy = (|blk_busy) | (|gbl_r);
  assign coherence_busy_o = any_busy;
////////////////////////////////////////////////////////////////////////////
// range attribute registers
  genvar g;
  generate
    for (g = 0; g < 256; g = g + 1) begin : attr
      if (g == 0) begin : fixed_one
        assign permit[g] = 1'b1;
      end else if (g <= 15) begin : fixed_zero
        assign permit[g] = 1'b0;
      end else begin : live
        reg bit_r;
        always @(posedge mclk_i or negedge rst_n_i) begin
          if (!rst_n_i) begin
            bit_r <= 1'b0;
          end else if (ce_i && reg_wr_i && attr_hit && attr_idx == g) begin
            bit_r <= reg_wdata_i[0];
          end
        end
        assign permit[g] = bit_r;
      end
    end
  endgenerate
////////////////////////////////////////////////////////////////////////////
// configuration and global controls
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r    <= `CFG_RESET;
      pflush_r <= 1'b0;
      dflush_r <= 1'b0;
    end else if (ce_i) begin
      pflush_r <= 1'b0;
      dflush_r <= 1'b0;
      if (reg_wr_i && reg_addr_i == `ADDR_L2_CONFIG) begin
        cfg_r    <= reg_wdata_i[`CFG_FREEZE_BIT:0];
        pflush_r <= reg_wdata_i[`CFG_PROG_FLUSH_BIT];
        dflush_r <= reg_wdata_i[`CFG_DATA_FLUSH_BIT];
      end
    end
  end
  assign program_cache_flush_all_o = pflush_r;
  assign data_cache_flush_all_o    = dflush_r;
  assign freeze_select_o           = cfg_r[`CFG_FREEZE_BIT];
  assign cache_size_select_o       = cfg_r[`CFG_SIZE_MSB:0];

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gbl_r  <= 3'b000;
      gcnt_r <= 8'h00;
    end else if (ce_i) begin
      if (gbl_r != 3'b000) begin
        if (gcnt_r == `OP_TICKS) begin
          gbl_r  <= 3'b000;
          gcnt_r <= 8'h00;
        end else begin
          gcnt_r <= gcnt_r + 8'h01;
        end
      end else if (reg_wr_i && reg_wdata_i[0] && !any_busy) begin
        if (reg_addr_i == `ADDR_GLOBAL_WB) gbl_r <= 3'b001;
        if (reg_addr_i == `ADDR_GLOBAL_WBINV) gbl_r <= 3'b010;
        if (reg_addr_i == `ADDR_GLOBAL_INV) gbl_r <= 3'b100;
      end
    end
  end
////////////////////////////////////////////////////////////////////////////
// block coherence operations
  generate
    for (g = 0; g < 3; g = g + 1) begin : blk
      wire [31:0] base_a;
      wire [31:0] cnt_a;
      wire        start;
      assign base_a = (g == 0) ? `ADDR_WB_BASE :
                      (g == 1) ? `ADDR_WBINV_BASE : `ADDR_INV_BASE;
      assign cnt_a  = (g == 0) ? `ADDR_WB_COUNT :
                      (g == 1) ? `ADDR_WBINV_COUNT : `ADDR_INV_COUNT;
      assign start  = reg_wr_i && reg_addr_i == cnt_a && !any_busy &&
                      reg_wdata_i[15:0] != 16'h0000;
      always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          base_r[g] <= 32'h00000000;
        end else if (ce_i && reg_wr_i && reg_addr_i == base_a &&
                     !any_busy) begin
          base_r[g] <= reg_wdata_i;
        end
      end
      coherence_op_seq u_seq (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .ce_i     (ce_i),
        .start_i  (start),
        .count_i  (reg_wdata_i[15:0]),
        .remain_o (remain[g]),
        .busy_o   (blk_busy[g])
      );
    end
  endgenerate
////////////////////////////////////////////////////////////////////////////
// register read port
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (ce_i) begin
      reg_rdata_o <= 32'h00000000;
      if (reg_rd_i) begin
        if (attr_hit) begin
          reg_rdata_o <= {31'h00000000, permit[attr_idx]};
        end else begin
          case (reg_addr_i)
            `ADDR_L2_CONFIG: reg_rdata_o <= {4'h0, CORE_COUNT_M1, 4'h0,
                                             CORE_ID, 12'h000, cfg_r};
            `ADDR_WB_COUNT:     reg_rdata_o <= {16'h0000, remain[0]};
            `ADDR_WBINV_COUNT:  reg_rdata_o <= {16'h0000, remain[1]};
            `ADDR_INV_COUNT:    reg_rdata_o <= {16'h0000, remain[2]};
            `ADDR_GLOBAL_WB:    reg_rdata_o <= {31'h00000000, gbl_r[0]};
            `ADDR_GLOBAL_WBINV: reg_rdata_o <= {31'h00000000, gbl_r[1]};
            `ADDR_GLOBAL_INV:   reg_rdata_o <= {31'h00000000, gbl_r[2]};
            default:            reg_rdata_o <= 32'h00000000;
          endcase
        end
      end
    end
  end
////////////////////////////////////////////////////////////////////////////
// l1 miss handling
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      long_access_o        <= 1'b0;
      allocate_o           <= 1'b0;
      data_l1_cache_keep_o <= 1'b0;
      nc_write_hit_o       <= 1'b0;
      lru_wb_req_o         <= 1'b0;
      long_busy_r          <= 1'b0;
    end else if (ce_i) begin
      long_access_o  <= 1'b0;
      allocate_o     <= 1'b0;
      nc_write_hit_o <= 1'b0;
      lru_wb_req_o   <= 1'b0;
      if (long_busy_r && long_read_done_i) begin
        long_busy_r <= 1'b0;
      end
      if (miss_req_i) begin
        if (miss_prog_i) begin
          data_l1_cache_keep_o <= 1'b1;
          allocate_o <= !miss_l2ram_i && !miss_l2hit_i &&
                        miss_permit && !cfg_r[`CFG_FREEZE_BIT] &&
                        cfg_r[`CFG_SIZE_MSB:0] != 3'h0;
          long_access_o <= !miss_l2ram_i && !miss_l2hit_i && !miss_permit;
          if (!miss_l2ram_i && !miss_l2hit_i && !miss_permit) begin
            long_busy_r <= 1'b1;
          end
        end else begin
          data_l1_cache_keep_o <= miss_permit || miss_l2ram_i;
          if (!miss_l2ram_i && !miss_l2hit_i) begin
            if (!miss_permit) begin
              long_access_o <= 1'b1;
              if (!miss_write_i) begin
                long_busy_r  <= 1'b1;
                lru_wb_req_o <= 1'b1;
              end
            end else begin
              allocate_o <= !cfg_r[`CFG_FREEZE_BIT] &&
                            cfg_r[`CFG_SIZE_MSB:0] != 3'h0;
            end
          end else if (miss_l2hit_i && miss_write_i && !miss_permit) begin
            nc_write_hit_o <= 1'b1;
          end
        end
      end
    end
  end
  assign cpu_stall_o = long_busy_r;
////////////////////////////////////////////////////////////////////////////
// victims and evictions
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      victim_to_ext_o    <= 1'b0;
      victim_set_dirty_o <= 1'b0;
      evict_wb_o         <= 1'b0;
    end else if (ce_i) begin
      victim_to_ext_o    <= victim_req_i && !victim_l2hit_i;
      victim_set_dirty_o <= victim_req_i && victim_l2hit_i;
      evict_wb_o         <= l2_evict_i && l2_evict_dirty_i;
    end
  end
////////////////////////////////////////////////////////////////////////////
// dma snoops through shadow tags
  wire [TAG_W+1:0] shadow_q;
  reg              dma_pend_r;
  reg              dma_wr_r;
  reg  [31:0]      dma_addr_r;
  shadow_tag_mem #(
    .IDX_W (IDX_W),
    .TAG_W (TAG_W)
  ) u_shadow (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .we_i    (shadow_we_i),
    .widx_i  (shadow_widx_i),
    .wdata_i (shadow_wdata_i),
    .ridx_i  (dma_addr_i[IDX_W+5:6]),
    .rdata_o (shadow_q)
  );
  wire tag_match;
  assign tag_match = shadow_q[TAG_W+1] &&
                     shadow_q[TAG_W-1:0] == dma_addr_r[31:32-TAG_W];
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dma_pend_r        <= 1'b0;
      dma_wr_r          <= 1'b0;
      dma_addr_r        <= 32'h00000000;
      snoop_read_cmd_o  <= 1'b0;
      snoop_write_cmd_o <= 1'b0;
      snoop_addr_o      <= 32'h00000000;
    end else if (ce_i) begin
      dma_pend_r <= dma_req_i;
      dma_wr_r   <= dma_write_i;
      dma_addr_r <= dma_addr_i;
      snoop_read_cmd_o  <= dma_pend_r && !dma_wr_r && tag_match &&
                           shadow_q[TAG_W];
      snoop_write_cmd_o <= dma_pend_r && dma_wr_r && tag_match;
      if (dma_pend_r) begin
        snoop_addr_o <= dma_addr_r;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/l2_coh_checker_sva.sv ====
// Purpose: port checks of the cacheability and coherence block
// Assumes: ce_i high whenever a request is made
// Notes: bound to the design top from the testbench
`timescale 1ns/1ns
`default_nettype none
`include "l2_cache_defines.vh"
module l2_coh_checker (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        miss_req_i,
  input wire logic        miss_prog_i,
  input wire logic        miss_write_i,
  input wire logic [31:0] miss_addr_i,
  input wire logic        miss_l2ram_i,
  input wire logic        miss_l2hit_i,
  input wire logic        long_access_o,
  input wire logic        allocate_o,
  input wire logic        data_l1_cache_keep_o,
  input wire logic        cpu_stall_o,
  input wire logic        lru_wb_req_o,
  input wire logic        long_read_done_i,
  input wire logic        victim_req_i,
  input wire logic        victim_l2hit_i,
  input wire logic        victim_to_ext_o,
  input wire logic        victim_set_dirty_o,
  input wire logic        l2_evict_i,
  input wire logic        l2_evict_dirty_i,
  input wire logic        evict_wb_o,
  input wire logic        dma_req_i,
  input wire logic        dma_write_i,
  input wire logic [31:0] dma_addr_i,
  input wire logic        snoop_read_cmd_o,
  input wire logic        snoop_write_cmd_o,
  input wire logic [31:0] snoop_addr_o,
  input wire logic        data_cache_flush_all_o
);
  logic nc;
  // double miss into a fixed non-cacheable range
  assign nc = miss_req_i && ce_i && !miss_l2ram_i && !miss_l2hit_i &&
              miss_addr_i[31:28] == 4'h0 && miss_addr_i[27:24] != 4'h0;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////
  a_nc_long: assert property (nc |=> long_access_o && !allocate_o)
    else $error("no long access on non-cacheable miss");
  a_nc_nokeep: assert property (nc && !miss_prog_i |=> !data_l1_cache_keep_o)
    else $error("non-cacheable data kept");
  a_prog_keep: assert property (miss_req_i && ce_i && miss_prog_i
    |=> data_l1_cache_keep_o)
    else $error("program fetch not kept");
  a_stall_set: assert property (nc && !miss_write_i |=> cpu_stall_o)
    else $error("long read without stall");
  a_lru_wb: assert property (nc && !miss_prog_i && !miss_write_i
    |=> lru_wb_req_o)
    else $error("no dirty lru writeback request");
  a_stall_hold: assert property (cpu_stall_o && !long_read_done_i
    |=> cpu_stall_o)
    else $error("stall dropped early");
  a_stall_end: assert property (long_read_done_i |=> ##[0:1] !cpu_stall_o)
    else $error("stall held after data");
  a_victim_ext: assert property (victim_req_i && ce_i && !victim_l2hit_i
    |=> victim_to_ext_o && !victim_set_dirty_o)
    else $error("missing victim not sent out");
  a_victim_hit: assert property (victim_req_i && ce_i && victim_l2hit_i
    |=> victim_set_dirty_o && !victim_to_ext_o && !allocate_o)
    else $error("hitting victim mishandled");
  a_evict_wb: assert property (l2_evict_i && ce_i
    |=> evict_wb_o == $past(l2_evict_dirty_i))
    else $error("eviction writeback wrong");
  a_snoop_src: assert property (snoop_read_cmd_o || snoop_write_cmd_o
    |-> $past(dma_req_i, 2) && snoop_addr_o == $past(dma_addr_i, 2))
    else $error("snoop without dma access");
  a_snoop_kind: assert property (snoop_read_cmd_o != snoop_write_cmd_o
    |-> snoop_write_cmd_o == $past(dma_write_i, 2))
    else $error("snoop kind wrong");
  a_flush_pulse: assert property (reg_wr_i && ce_i &&
    reg_addr_i == `ADDR_L2_CONFIG && reg_wdata_i[8]
    |=> data_cache_flush_all_o ##1 !data_cache_flush_all_o)
    else $error("data flush pulse wrong");
  c_long: cover property (long_access_o && cpu_stall_o);
  c_snoop_rd: cover property (snoop_read_cmd_o);
  c_snoop_wr: cover property (snoop_write_cmd_o);
endmodule
`default_nettype wire

// ==== bench/long_read_responder.sv ====
// Purpose: far-side model answering long-distance reads
// Assumes: one long read outstanding at a time
// Notes: answer delay set by the bench
`timescale 1ns/1ns
`default_nettype none
module long_read_responder (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       long_i,
  input  wire logic       stall_i,
  input  wire logic [3:0] delay_i,
  output var  logic       done_o
);
  logic [3:0] cnt_r;
  logic       busy_r;
  // read data return delay_i+1 cycles after the long read is accepted
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r <= 1'h0;
      cnt_r  <= 4'h0;
      done_o <= 1'h0;
    end else begin
      done_o <= busy_r && cnt_r == 4'h0;
      if (long_i && stall_i && !busy_r) begin
        busy_r <= 1'h1;
        cnt_r  <= delay_i;
      end else if (busy_r) begin
        busy_r <= cnt_r != 4'h0;
        cnt_r  <= cnt_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb_l2_cacheability_and_l1_coherence.sv ====
// Purpose: self-checking bench of the cacheability controller
// Assumes: ce_i held high except for one dropped attribute write
// Notes: long reads answered by long_read_responder
`timescale 1ns/1ns
`default_nettype none
`include "l2_cache_defines.vh"
module tb_l2_cacheability_and_l1_coherence;
  logic        mclk_i = 1'h0, rst_n_i = 1'h0, ce_i = 1'h1;
  logic        reg_wr_i = 1'h0, reg_rd_i = 1'h0, miss_req_i = 1'h0;
  logic        miss_prog_i = 1'h0, miss_write_i = 1'h0;
  logic        miss_l2ram_i = 1'h0, miss_l2hit_i = 1'h0;
  logic        victim_req_i = 1'h0, victim_l2hit_i = 1'h0;
  logic        l2_evict_i = 1'h0, l2_evict_dirty_i = 1'h0;
  logic        shadow_we_i = 1'h0, dma_req_i = 1'h0, dma_write_i = 1'h0;
  logic [31:0] reg_addr_i = 32'h0, reg_wdata_i = 32'h0;
  logic [31:0] miss_addr_i = 32'h0, dma_addr_i = 32'h0;
  logic [5:0]  shadow_widx_i = 6'h0;
  logic [21:0] shadow_wdata_i = 22'h0;
  logic [31:0] reg_rdata_o, snoop_addr_o;
  logic [2:0]  cache_size_select_o;
  logic [3:0]  dly = 4'h1;
  logic        long_read_done_i, long_access_o, allocate_o, cpu_stall_o;
  logic        data_l1_cache_keep_o, nc_write_hit_o, lru_wb_req_o;
  logic        victim_to_ext_o, victim_set_dirty_o, evict_wb_o;
  logic        snoop_read_cmd_o, snoop_write_cmd_o, freeze_select_o;
  logic        program_cache_flush_all_o, data_cache_flush_all_o;
  logic        coherence_busy_o;
  logic [4:0]  mo;
  int          err_count = 0, num_checks = 0, i, n;
  localparam logic [31:0] AT = `ADDR_ATTR_BASE;
  localparam logic [31:0] CF = `ADDR_L2_CONFIG;
  localparam logic [31:0] DA = 32'h00800140;
  assign mo = {cpu_stall_o, long_access_o, allocate_o,
               data_l1_cache_keep_o, nc_write_hit_o};
  always #2 mclk_i = ~mclk_i;
  l2_cacheability_and_l1_coherence #(.CORE_COUNT_M1(4'h3), .CORE_ID(4'h5))
    l2_cacheability_and_l1_coherence_inst (.*);
  long_read_responder long_read_responder_inst (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .long_i(long_access_o), .stall_i(cpu_stall_o),
    .delay_i(dly), .done_o(long_read_done_i));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'h0;
    #1;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'h0;
    #1 chk(reg_rdata_o, exp);
  endtask
  task miss(input logic [31:0] a, input logic [3:0] c,
            input logic [4:0] m, input logic [4:0] e);
    @(posedge mclk_i);
    miss_req_i <= 1'h1;
    miss_addr_i <= a;
    {miss_prog_i, miss_write_i, miss_l2ram_i, miss_l2hit_i} <= c;
    @(posedge mclk_i);
    miss_req_i <= 1'h0;
    #1 chk(mo & m, e);
    for (n = 0; n < 40 && cpu_stall_o !== 1'h0; n++) @(posedge mclk_i);
  endtask
  task sh(input logic [21:0] d);
    @(posedge mclk_i);
    shadow_we_i <= 1'h1;
    shadow_widx_i <= 6'h5;
    shadow_wdata_i <= d;
    @(posedge mclk_i);
    shadow_we_i <= 1'h0;
  endtask
  task dma(input logic [31:0] a, input logic w, input logic [1:0] e);
    @(posedge mclk_i);
    dma_req_i <= 1'h1;
    dma_write_i <= w;
    dma_addr_i <= a;
    @(posedge mclk_i);
    dma_req_i <= 1'h0;
    @(posedge mclk_i);
    #1 chk({snoop_read_cmd_o, snoop_write_cmd_o}, e);
  endtask
  task vx(input logic [3:0] c, input logic [2:0] e);
    @(posedge mclk_i);
    {victim_req_i, victim_l2hit_i, l2_evict_i, l2_evict_dirty_i} <= c;
    @(posedge mclk_i);
    {victim_req_i, victim_l2hit_i, l2_evict_i, l2_evict_dirty_i} <= 4'h0;
    #1 chk({victim_to_ext_o, victim_set_dirty_o, evict_wb_o}, e);
  endtask
  task idle;
    for (n = 0; n < 200 && coherence_busy_o !== 1'h0; n++) @(posedge mclk_i);
  endtask
  task end_sim;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    err_count++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    rd(CF, 32'h03050000);
    rd(AT, 32'h1);
    wr(AT, 32'h0);
    rd(AT, 32'h1);
    wr(AT + 32'h1c, 32'h1);
    for (i = 1; i < 16; i++) rd(AT + 4 * i, 32'h0);
    rd(AT + 32'h80, 32'h0);
    wr(AT + 32'h80, 32'hffffffff);
    rd(AT + 32'h80, 32'h1);
    ce_i <= 1'h0;
    wr(AT + 32'h80, 32'h0);
    ce_i <= 1'h1;
    rd(AT + 32'h80, 32'h1);
    rd(32'h01846000, 32'h0);
    $display("test attributes done");
    miss(32'h20000000, 4'h0, 5'h1f, 5'h02);
    miss(32'h30000000, 4'h4, 5'h1f, 5'h08);
    miss(32'h30000000, 4'h5, 5'h1f, 5'h01);
    miss(32'h00800000, 4'h2, 5'h1f, 5'h02);
    miss(32'h05000000, 4'h0, 5'h1f, 5'h18);
    miss(32'h30000000, 4'h8, 5'h1f, 5'h1a);
    dly <= 4'h6;
    miss(32'h30000000, 4'h0, 5'h1f, 5'h18);
    chk(n > 6 && n < 14, 32'h1);
    $display("test misses done");
    for (i = 0; i < 8; i++) begin
      wr(CF, i);
      chk(cache_size_select_o, i);
    end
    miss(32'h20000000, 4'h0, 5'h1f, 5'h06);
    wr(CF, 32'h30d);
    chk({program_cache_flush_all_o, freeze_select_o}, 32'h3);
    rd(CF, 32'h0305000d);
    miss(32'h20000000, 4'h0, 5'h04, 5'h00);
    $display("test config done");
    sh(22'h300800);
    dma(DA, 1'h0, 2'h2);
    dma(DA, 1'h0, 2'h2);
    dma(DA, 1'h1, 2'h1);
    dma(DA + 32'h1000, 1'h1, 2'h0);
    sh(22'h200800);
    dma(DA, 1'h0, 2'h0);
    dma(DA, 1'h1, 2'h1);
    sh(22'h000800);
    dma(DA, 1'h1, 2'h0);
    $display("test snoops done");
    vx(4'h8, 3'h4);
    vx(4'hc, 3'h2);
    vx(4'h3, 3'h1);
    vx(4'h2, 3'h0);
    $display("test victims done");
    wr(`ADDR_WB_BASE, 32'h00800000);
    wr(`ADDR_WB_COUNT, 32'h400);
    chk(coherence_busy_o, 32'h1);
    idle;
    rd(`ADDR_WB_COUNT, 32'h0);
    wr(`ADDR_INV_COUNT, 32'hffe1);
    chk(coherence_busy_o, 32'h0);
    wr(`ADDR_GLOBAL_INV, 32'h1);
    rd(`ADDR_GLOBAL_INV, 32'h1);
    idle;
    rd(`ADDR_GLOBAL_INV, 32'h0);
    $display("test coherence ops done");
    end_sim;
  end
endmodule
bind l2_cacheability_and_l1_coherence l2_coh_checker l2_coh_checker_inst (.*);
`default_nettype wire
